//--- rtl/fxs_crosspoint.sv
// Top of the fiber-to-SDI crosspoint with status and register port
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Every output has its own selector picking the fiber input that feeds it.
// - One input may feed several outputs at once, as a distribution amplifier.
// - Only fitted inputs can be selected; other selections are ignored.
// - Each output reports 3G, HD or SD when its rate matches that standard.
// - Usable but non-standard signals report a generic valid format.
// - A recognised standard rate on an output reports reclocker locked.
// - A passed but unrecognised signal reports the no-lock indication.
// - Rate detection and reclocking cover 19 Mbps up to 3 Gbps.
// - Reclock buffering sits ahead of the automute stage in each path.
// - Automute blanks output data while the reclocker is not locked.
// - Per output, reclock bypass lets non-standard signals through unmuted.
// - Rate and lock status of all four outputs is readable by software.
// - Reset leaves reclock bypass off and automute on for every output.
module fxs_crosspoint
  import fxs_pkg::*;
#(
  parameter int NUM_INPUTS = IN_MAX
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire fxs_stream_t fiberIn [IN_MAX],
  output logic [IN_MAX-1:0] fiberReady,
  output fxs_stream_t sdiOut [OUT_NUM],
  input wire logic [OUT_NUM-1:0] sdiReady,
  output fxs_status_t sdiStatus [OUT_NUM]
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel_ff [OUT_NUM];
  logic [SEL_W-1:0] nxt_sel [OUT_NUM];
  logic [OUT_NUM-1:0] selChg_ff, nxt_selChg;
  logic [OUT_NUM-1:0] bypass_ff, nxt_bypass;
  logic [OUT_NUM-1:0] automute_ff, nxt_automute;
  logic [31:0] rdData_ff, nxt_rdData;
  logic [IN_MAX-1:0] ready_ff, nxt_ready;
  logic wrSel, wrCtrl;
  localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;

  fxs_stream_t pathIn [OUT_NUM];
  logic [OUT_NUM-1:0] pathReady;
  fxs_status_t pathStatus [OUT_NUM];

  // Default routing is straight through where that input is fitted
  function automatic logic [SEL_W-1:0] sel_reset(input int o);
    sel_reset = (o < NUM_INPUTS) ? SEL_W'(o) : '0;
  endfunction

  function automatic logic fitted(input logic [SEL_W-1:0] s);
    fitted = (int'(s) < NUM_INPUTS);
  endfunction

  // Source field of one output within a route word
  function automatic logic [SEL_W-1:0] sel_field(input logic [31:0] d, input int o);
    sel_field = d[o*SEL_W +: SEL_W];
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Write decode, shared by the route and control registers
  assign wrSel = regWr && (regAddr == OFS_SEL);
  assign wrCtrl = regWr && (regAddr == OFS_CTRL);

  always_comb begin
    nxt_bypass = bypass_ff;
    nxt_automute = automute_ff;
    nxt_selChg = '0;
    for (int o = 0; o < OUT_NUM; o++) begin
      nxt_sel[o] = sel_ff[o];
    end
    if (wrSel) begin
      for (int o = 0; o < OUT_NUM; o++) begin
        // A source that is not fitted leaves the old route in place
        if (fitted(sel_field(regWrData, o))) begin
          nxt_sel[o] = sel_field(regWrData, o);
          nxt_selChg[o] = (sel_field(regWrData, o) != sel_ff[o]);
        end
      end
    end
    if (wrCtrl) begin
      nxt_bypass = regWrData[CTRL_BYP_LSB +: OUT_NUM];
      nxt_automute = regWrData[CTRL_MUTE_LSB +: OUT_NUM];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int o = 0; o < OUT_NUM; o++) begin
        sel_ff[o] <= sel_reset(o);
      end
      selChg_ff <= '0;
      bypass_ff <= BYP_RST;
      automute_ff <= MUTE_RST;
    end else begin
      for (int o = 0; o < OUT_NUM; o++) begin
        sel_ff[o] <= nxt_sel[o];
      end
      selChg_ff <= nxt_selChg;
      bypass_ff <= nxt_bypass;
      automute_ff <= nxt_automute;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdData = '0;
    if (regRd) begin
      case (regAddr)
        OFS_SEL: begin
          for (int o = 0; o < OUT_NUM; o++) begin
            nxt_rdData[o*SEL_W +: SEL_W] = sel_ff[o];
          end
        end
        OFS_CTRL: begin
          nxt_rdData[CTRL_BYP_LSB +: OUT_NUM] = bypass_ff;
          nxt_rdData[CTRL_MUTE_LSB +: OUT_NUM] = automute_ff;
        end
        OFS_STAT: begin
          for (int o = 0; o < OUT_NUM; o++) begin
            nxt_rdData[o*STAT_STRIDE +: STAT_FLD_W] = pathStatus[o];
          end
        end
        OFS_INFO: begin
          nxt_rdData[2:0] = 3'(NUM_INPUTS);
        end
        default: begin
          nxt_rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

  // ----------------------------------------------------------------
  // Crossbar
  // ----------------------------------------------------------------
  always_comb begin
    for (int o = 0; o < OUT_NUM; o++) begin
      pathIn[o] = fiberIn[sel_ff[o]];
      // Hold the path idle while its route is being switched
      if (selChg_ff[o]) begin
        pathIn[o].valid = 1'b0;
      end
    end
  end

  // An input advances only when every output it feeds has room
  always_comb begin
    for (int i = 0; i < IN_MAX; i++) begin
      nxt_ready[i] = (i < NUM_INPUTS);
      for (int o = 0; o < OUT_NUM; o++) begin
        if (int'(sel_ff[o]) == i && !pathReady[o]) begin
          nxt_ready[i] = 1'b0;
        end
      end
    end
  end

  // Ready lags one cycle; the FIFO headroom absorbs the extra word
  always_ff @(posedge clock) begin
    if (rst) begin
      ready_ff <= '0;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  assign fiberReady = ready_ff;

  // ----------------------------------------------------------------
  // Output paths
  // ----------------------------------------------------------------
  for (genvar o = 0; o < OUT_NUM; o++) begin : g_path
    fxs_stream_t gatedIn;
    logic fifoReady;
    logic [FILL_W-1:0] fill_ff, nxt_fill;
    logic push, pop;

    always_comb begin
      gatedIn = pathIn[o];
      // Word counts as taken only when the shared input really moves
      gatedIn.valid = pathIn[o].valid && ready_ff[sel_ff[o]];
    end

    fxs_out_path #(.DEPTH(FIFO_DEPTH)) u_path (
      .clock(clock),
      .rst(rst),
      .selChanged(selChg_ff[o]),
      .bypassReclock(bypass_ff[o]),
      .automuteEn(automute_ff[o]),
      .inStream(gatedIn),
      .inReady(fifoReady),
      .outStream(sdiOut[o]),
      .outReady(sdiReady[o]),
      .status(pathStatus[o])
    );

    // Local copy of the buffer fill, so no reference reaches into the path
    always_comb begin
      push = gatedIn.valid && fifoReady;
      // Buffer pops whenever its output register is free or being taken
      pop = (fill_ff != '0) && (!sdiOut[o].valid || sdiReady[o]);
      nxt_fill = fill_ff;
      if (push && !pop) begin
        nxt_fill = fill_ff + 1'b1;
      end else if (pop && !push) begin
        nxt_fill = fill_ff - 1'b1;
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        fill_ff <= '0;
      end else begin
        fill_ff <= nxt_fill;
      end
    end

    // Keep one slot free so the late ready never overruns
    assign pathReady[o] = fifoReady && !(gatedIn.valid &&
                          fill_ff == FILL_W'(FIFO_DEPTH - 1));
    assign sdiStatus[o] = pathStatus[o];
  end

endmodule
`default_nettype wire

//--- rtl/fxs_pkg.sv
// Shared constants, types and helpers of the fiber-to-SDI crosspoint
package fxs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 20;
  localparam int IN_MAX = 4;
  localparam int OUT_NUM = 4;
  localparam int SEL_W = 2;
  localparam int CNT_W = 13;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Timing and rate classification
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int WINDOW_CYC = 4096;
  localparam int RATE_3G_MBPS = 2970;
  localparam int RATE_HD_MBPS = 1485;
  localparam int RATE_SD_MBPS = 270;
  localparam int RATE_MIN_MBPS = 19;
  localparam int RATE_MAX_MBPS = 3000;
  localparam int TOL_PCT = 2;

  // Words expected in one window for a given line rate
  function automatic int words_for(input int mbps);
    words_for = (mbps * WINDOW_CYC) / (CLK_MHZ * WORD_W);
  endfunction

  localparam int CNT_3G = words_for(RATE_3G_MBPS);
  localparam int CNT_HD = words_for(RATE_HD_MBPS);
  localparam int CNT_SD = words_for(RATE_SD_MBPS);
  localparam int CNT_MIN = words_for(RATE_MIN_MBPS);
  localparam int CNT_MAX = words_for(RATE_MAX_MBPS) + 1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_SEL = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_INFO = 4'hC;
  localparam int CTRL_BYP_LSB = 0;
  localparam int CTRL_MUTE_LSB = 4;
  localparam int STAT_FLD_W = 5;
  localparam int STAT_STRIDE = 8;
  localparam logic [3:0] BYP_RST = 4'h0;
  localparam logic [3:0] MUTE_RST = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {FMT_NONE, FMT_SD, FMT_HD, FMT_3G, FMT_VALID} fxs_fmt_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } fxs_stream_t;

  typedef struct packed {
    fxs_fmt_t fmt;
    logic locked;
    logic noLock;
  } fxs_status_t;

  function automatic logic in_band(input int cnt, input int nominal);
    in_band = (cnt * 100 >= nominal * (100 - TOL_PCT)) &&
              (cnt * 100 <= nominal * (100 + TOL_PCT));
  endfunction

endpackage

//--- rtl/fxs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module fxs_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [PTR_W:0] count_ff, nxt_count;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  assign inReady = (count_ff != PTR_W'(0) + (PTR_W+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem[rdPtr_ff];

  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    nxt_wrPtr = push ? PTR_W'((wrPtr_ff + 1'b1) % DEPTH) : wrPtr_ff;
    nxt_rdPtr = pop ? PTR_W'((rdPtr_ff + 1'b1) % DEPTH) : rdPtr_ff;
    nxt_count = count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Storage has no reset; only words below count are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

endmodule
`default_nettype wire

//--- rtl/fxs_out_path.sv
// One output path: rate detection, reclock buffer and automute
`timescale 1ns/10ps
`default_nettype none
module fxs_out_path
  import fxs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic selChanged,
  input wire logic bypassReclock,
  input wire logic automuteEn,
  input wire fxs_stream_t inStream,
  output logic inReady,
  output fxs_stream_t outStream,
  input wire logic outReady,
  output fxs_status_t status
);
  logic [CNT_W-1:0] winCnt_ff, nxt_winCnt, wordCnt_ff, nxt_wordCnt;
  fxs_status_t status_ff, nxt_status;
  fxs_stream_t out_ff, nxt_out;
  logic fifoValid, fifoReady;
  logic [WORD_W-1:0] fifoData;
  logic mute;

  // ----------------------------------------------------------------
  // Reclock buffer
  // ----------------------------------------------------------------
  fxs_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(inStream.valid),
    .inReady(inReady),
    .inData(inStream.data),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // ----------------------------------------------------------------
  // Rate detection over a fixed window
  // ----------------------------------------------------------------
  function automatic fxs_status_t classify(input logic [CNT_W-1:0] cnt);
    int c;
    c = int'(cnt);
    classify.fmt = FMT_NONE;
    if (in_band(c, CNT_3G)) begin
      classify.fmt = FMT_3G;
    end else if (in_band(c, CNT_HD)) begin
      classify.fmt = FMT_HD;
    end else if (in_band(c, CNT_SD)) begin
      classify.fmt = FMT_SD;
    end else if (c >= CNT_MIN && c <= CNT_MAX) begin
      classify.fmt = FMT_VALID;
    end
    classify.locked = (classify.fmt == FMT_3G) || (classify.fmt == FMT_HD) ||
                      (classify.fmt == FMT_SD);
    classify.noLock = !classify.locked;
  endfunction

  always_comb begin
    nxt_winCnt = winCnt_ff + 1'b1;
    nxt_wordCnt = wordCnt_ff + CNT_W'(inStream.valid && inReady);
    nxt_status = status_ff;
    if (selChanged) begin
      // Old source's count says nothing about the new one
      nxt_winCnt = '0;
      nxt_wordCnt = '0;
      nxt_status = '{fmt: FMT_NONE, locked: 1'b0, noLock: 1'b1};
    end else if (winCnt_ff == CNT_W'(WINDOW_CYC - 1)) begin
      nxt_winCnt = '0;
      nxt_wordCnt = '0;
      nxt_status = classify(wordCnt_ff);
    end
  end

  // ----------------------------------------------------------------
  // Automute after the reclock stage
  // ----------------------------------------------------------------
  assign mute = automuteEn && !bypassReclock && !status_ff.locked;
  assign fifoReady = !out_ff.valid || outReady;

  always_comb begin
    nxt_out = out_ff;
    if (fifoReady) begin
      nxt_out.valid = fifoValid;
      nxt_out.data = mute ? '0 : fifoData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      winCnt_ff <= '0;
      wordCnt_ff <= '0;
      status_ff <= '{fmt: FMT_NONE, locked: 1'b0, noLock: 1'b1};
      out_ff <= '0;
    end else begin
      winCnt_ff <= nxt_winCnt;
      wordCnt_ff <= nxt_wordCnt;
      status_ff <= nxt_status;
      out_ff <= nxt_out;
    end
  end

  assign outStream = out_ff;
  assign status = status_ff;

endmodule
`default_nettype wire

//--- sim/fxs_crosspoint_monitor.sv
// Port checker for the crosspoint
`timescale 1ns/10ps
`default_nettype none
module fxs_crosspoint_monitor
  import fxs_pkg::*;
#(
  parameter int NUM_INPUTS = IN_MAX
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire fxs_stream_t fiberIn [IN_MAX],
  input wire logic [IN_MAX-1:0] fiberReady,
  input wire fxs_stream_t sdiOut [OUT_NUM],
  input wire logic [OUT_NUM-1:0] sdiReady,
  input wire fxs_status_t sdiStatus [OUT_NUM]
);
  // ----------
  // Shadow of routing and control
  // ----------
  logic [7:0] sel_ff;
  logic [7:0] nxt_sel;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  always_comb begin
    nxt_sel = sel_ff;
    nxt_ctrl = ctrl_ff;
    if (regWr && regAddr == OFS_CTRL) begin
      nxt_ctrl = regWrData[7:0];
    end
    for (int o = 0; o < OUT_NUM; o++) begin
      if (regWr && regAddr == OFS_SEL && int'(regWrData[2*o+:2]) < NUM_INPUTS) begin
        nxt_sel[2*o+:2] = regWrData[2*o+:2];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= {MUTE_RST, BYP_RST};
      for (int o = 0; o < OUT_NUM; o++) begin
        sel_ff[2*o+:2] <= (o < NUM_INPUTS) ? 2'(o) : 2'h0;
      end
    end else begin
      ctrl_ff <= nxt_ctrl;
      sel_ff <= nxt_sel;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ----------
  // Checks
  // ----------
  for (genvar o = 0; o < OUT_NUM; o++) begin : g_out
    property p_lock_fmt;
      sdiStatus[o].locked == (sdiStatus[o].fmt inside {FMT_SD, FMT_HD, FMT_3G})
        && sdiStatus[o].noLock == !sdiStatus[o].locked;
    endproperty
    a_lock_fmt: assert property (p_lock_fmt)
      else $error("lock flags and format disagree");
    // Three quiet cycles so words already in flight are not judged
    property p_mute;
      (ctrl_ff[CTRL_MUTE_LSB+o] && !ctrl_ff[CTRL_BYP_LSB+o] && !sdiStatus[o].locked)[*3]
        ##0 sdiOut[o].valid |-> sdiOut[o].data == '0;
    endproperty
    a_mute: assert property (p_mute)
      else $error("unlocked output not blanked");
    property p_hold;
      sdiOut[o].valid && !sdiReady[o] |=> sdiOut[o].valid && $stable(sdiOut[o].data);
    endproperty
    a_hold: assert property (p_hold)
      else $error("stalled output word changed");
    property p_rst_stat;
      disable iff (1'b0) rst |=> sdiStatus[o].fmt == FMT_NONE && sdiStatus[o].noLock;
    endproperty
    a_rst_stat: assert property (p_rst_stat)
      else $error("status not cleared by reset");
    property p_sel_new;
      regWr && regAddr == OFS_SEL && regWrData[2*o+:2] != sel_ff[2*o+:2]
        && int'(regWrData[2*o+:2]) < NUM_INPUTS |-> ##[1:2] sdiStatus[o].fmt == FMT_NONE;
    endproperty
    a_sel_new: assert property (p_sel_new)
      else $error("status kept after new route");
  end
  property p_info;
    regRd && regAddr == OFS_INFO |=> regRdData[2:0] == 3'(NUM_INPUTS);
  endproperty
  a_info: assert property (p_info)
    else $error("fitted input count wrong");
  property p_unfit;
    (fiberReady >> NUM_INPUTS) == '0;
  endproperty
  a_unfit: assert property (p_unfit)
    else $error("absent input accepts words");
  property p_stat;
    regRd && regAddr == OFS_STAT |=> regRdData[4:0] == $past(sdiStatus[0]);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read differs from port");
endmodule
bind fxs_crosspoint fxs_crosspoint_monitor #(.NUM_INPUTS(NUM_INPUTS)) i_mon (
  .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fiberIn(fiberIn),
  .fiberReady(fiberReady), .sdiOut(sdiOut), .sdiReady(sdiReady), .sdiStatus(sdiStatus));
`default_nettype wire

//--- sim/fxs_link_model.sv
// Fiber receivers and output drivers around the crosspoint
`timescale 1ns/10ps
`default_nettype none
module fxs_link_model
  import fxs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] step [IN_MAX],
  input wire logic [OUT_NUM-1:0] stall,
  input wire logic [IN_MAX-1:0] fiberReady,
  output fxs_stream_t fiberIn [IN_MAX],
  output logic [OUT_NUM-1:0] sdiReady
);
  // ----------
  // Rate by phase accumulator: step words per 4096 cycles
  // ----------
  logic [11:0] acc [IN_MAX];
  logic [12:0] sum [IN_MAX];
  logic [15:0] cnt [IN_MAX];
  assign sdiReady = ~stall;
  always_comb begin
    for (int i = 0; i < IN_MAX; i++) begin
      sum[i] = {1'b0, acc[i]} + {1'b0, step[i]};
    end
  end
  always_ff @(posedge clock) begin
    for (int i = 0; i < IN_MAX; i++) begin
      if (rst) begin
        acc[i] <= 12'h0;
        cnt[i] <= 16'h0;
        fiberIn[i] <= '0;
      end else if (!fiberIn[i].valid || fiberReady[i]) begin
        acc[i] <= sum[i][11:0];
        fiberIn[i].valid <= sum[i][12];
        cnt[i] <= cnt[i] + 16'(sum[i][12]);
        // Idle data toggles so a stale word is never mistaken for a fresh one
        fiberIn[i].data <= sum[i][12] ? {4'hA, cnt[i]} : ~fiberIn[i].data;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the crosspoint
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import fxs_pkg::*;
;
  localparam int FIT = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  fxs_stream_t fiberIn [IN_MAX];
  logic [IN_MAX-1:0] fiberReady;
  fxs_stream_t sdiOut [OUT_NUM];
  logic [OUT_NUM-1:0] sdiReady;
  fxs_status_t sdiStatus [OUT_NUM];
  logic [11:0] step [IN_MAX] = '{default: 12'h0};
  logic [OUT_NUM-1:0] stall = '0;
  fxs_fmt_t ea [OUT_NUM];
  int errorCnt = 0;
  int nTests = 0;
  always #2 clock = ~clock;
  fxs_crosspoint #(.NUM_INPUTS(FIT)) i_dut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .fiberIn(fiberIn), .fiberReady(fiberReady), .sdiOut(sdiOut), .sdiReady(sdiReady),
    .sdiStatus(sdiStatus));
  fxs_link_model i_far (.clock(clock), .rst(rst), .step(step), .stall(stall),
    .fiberReady(fiberReady), .fiberIn(fiberIn), .sdiReady(sdiReady));
  // ----------
  // Helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [4:0] stat_of(input fxs_fmt_t f);
    logic lk;
    lk = f inside {FMT_SD, FMT_HD, FMT_3G};
    stat_of = {f, lk, !lk};
  endfunction
  // Strobe is lowered then one edge passes, so back-to-back calls never clash
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 check(regRdData, exp, "read data");
    @(posedge clock);
  endtask
  task automatic chk_status();
    reg_rd(OFS_STAT, {3'h0, stat_of(ea[3]), 3'h0, stat_of(ea[2]), 3'h0, stat_of(ea[1]),
      3'h0, stat_of(ea[0])});
    #1;
    for (int o = 0; o < OUT_NUM; o++) begin
      check(32'(sdiStatus[o]), 32'(stat_of(ea[o])), "status");
    end
    @(posedge clock);
  endtask
  // Source words carry a fixed top nibble, so a live word is told from a blank one
  task automatic chk_mute(input int o, input logic muted);
    int k;
    k = 0;
    #1;
    while (sdiOut[o].valid !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1 k++;
    end
    check({sdiOut[o].valid, sdiOut[o].data == '0, sdiOut[o].data[19:16]},
      {1'b1, muted, muted ? 4'h0 : 4'hA}, "output blanking");
    @(posedge clock);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (2 * WINDOW_CYC + 3 * WINDOW_CYC + 24000) @(posedge clock);
    errorCnt++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reg_rd(OFS_SEL, 32'h24);
    reg_rd(OFS_CTRL, 32'hF0);
    reg_rd(OFS_INFO, 32'(FIT));
    reg_rd(4'h1, 32'h0);
    ea = '{default: FMT_NONE};
    chk_status();
    $display("test reset done");
    step <= '{12'(CNT_3G), 12'(CNT_HD), 12'h3E8, 12'h0};
    repeat (2 * WINDOW_CYC + 200) @(posedge clock);
    ea = '{FMT_3G, FMT_HD, FMT_VALID, FMT_3G};
    chk_status();
    chk_mute(2, 1'b1);
    chk_mute(0, 1'b0);
    #1 check(fiberReady[3], 1'b0, "absent input ready");
    @(posedge clock);
    $display("test rates done");
    reg_wr(OFS_SEL, 32'hE4);
    reg_rd(OFS_SEL, 32'h24);
    step[1] <= 12'(CNT_SD);
    reg_wr(OFS_CTRL, 32'hF4);
    reg_rd(OFS_CTRL, 32'hF4);
    reg_wr(OFS_SEL, 32'h68);
    #1 check(sdiStatus[1], stat_of(FMT_NONE), "rerouted status");
    check(sdiStatus[3], stat_of(FMT_NONE), "rerouted status");
    @(posedge clock);
    repeat (2 * WINDOW_CYC + 200) @(posedge clock);
    ea = '{FMT_3G, FMT_VALID, FMT_VALID, FMT_SD};
    chk_status();
    chk_mute(2, 1'b0);
    chk_mute(1, 1'b1);
    // Automute off on an unlocked output lets its words through
    reg_wr(OFS_CTRL, 32'hD4);
    reg_rd(OFS_CTRL, 32'hD4);
    chk_mute(1, 1'b0);
    $display("test reroute done");
    stall <= 4'h1;
    repeat (30) @(posedge clock);
    #1 check(fiberReady[0], 1'b0, "full path ready");
    stall <= 4'h0;
    repeat (30) @(posedge clock);
    #1 check(fiberReady[0], 1'b1, "drained path ready");
    $display("test stall done");
    finish_test();
  end
endmodule
`default_nettype wire
